//--- logic/bpc_port.sv
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_port #(
    parameter int PORT_WIDTH = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_soft_reset,
    input  wire logic [7:0]        i_addr,
    input  wire logic              i_rd,
    input  wire logic              i_wr,
    input  wire bpc_pkg::bpc_byte_type i_wdata,
    input  wire bpc_pkg::bpc_byte_type i_wmask,
    output bpc_pkg::bpc_byte_type  o_rdata,
    input  wire bpc_pkg::bpc_byte_type i_pin_in,
    output bpc_pkg::bpc_byte_type  o_pin_out,
    output bpc_pkg::bpc_byte_type  o_pin_oe,
    output bpc_pkg::bpc_byte_type  o_pullup_en,
    output logic                   o_change_flag,
    output logic                   o_wake,
    output logic                   o_ext_irq_in,
    input  wire logic              i_prog_mode,
    input  wire logic              i_prog_data_out,
    input  wire logic              i_prog_data_oe,
    output logic                   o_prog_clock,
    output logic                   o_prog_data_in
);
    bpc_pkg::bpc_byte_type port_b_data;
    bpc_pkg::bpc_byte_type port_b_direction;
    bpc_pkg::bpc_byte_type core_option_config;
    bpc_pkg::bpc_byte_type pins;
    bpc_pkg::bpc_byte_type next_rdata;
    bpc_pkg::bpc_byte_type next_pin_out;
    bpc_pkg::bpc_byte_type next_pin_oe;
    logic                  port_hit;
    logic                  change_flag;
    logic                  change_clear;

    if (PORT_WIDTH != 8) begin : g_bad_width
        $error("bpc_port serves an eight-bit port only");
    end

    function automatic bpc_pkg::bpc_byte_type merge(input bpc_pkg::bpc_byte_type base,
                                                     input bpc_pkg::bpc_byte_type data,
                                                     input bpc_pkg::bpc_byte_type mask);
        merge = (base & ~mask) | (data & mask);
    endfunction : merge

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    bpc_sync #(
        .WIDTH (PORT_WIDTH)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_pin_in),
        .o_sync  (pins)
    );

    assign port_hit     = hit(i_addr, `BPC_ADDR_PORT) && (i_rd || i_wr);
    // port access first, then flag clear, is the software order
    assign change_clear = i_wr && hit(i_addr, `BPC_ADDR_INTCTL)
                          && i_wmask[`BPC_INT_CHANGE]
                          && !i_wdata[`BPC_INT_CHANGE];

    bpc_change_detect u_change (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_pins     (pins[`BPC_CHANGE_HI:`BPC_CHANGE_LO]),
        .i_dir      (port_b_direction[`BPC_CHANGE_HI:`BPC_CHANGE_LO]),
        .i_refresh  (port_hit),
        .i_clear    (change_clear),
        .o_flag     (change_flag),
        .o_mismatch ()
    );

    // latch is not touched by the soft reset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            port_b_data <= `BPC_LATCH_POR;
        end else if (i_wr && hit(i_addr, `BPC_ADDR_PORT)) begin
            port_b_data <= merge(pins, i_wdata, i_wmask);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            port_b_direction <= `BPC_DIR_RESET;
        end else if (i_soft_reset) begin
            port_b_direction <= `BPC_DIR_RESET;
        end else if (i_wr && hit(i_addr, `BPC_ADDR_DIR)) begin
            port_b_direction <= merge(port_b_direction, i_wdata, i_wmask);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            core_option_config <= `BPC_OPTION_RESET;
        end else if (i_soft_reset) begin
            core_option_config <= `BPC_OPTION_RESET;
        end else if (i_wr && hit(i_addr, `BPC_ADDR_OPTION)) begin
            core_option_config <= merge(core_option_config, i_wdata, i_wmask);
        end
    end

    always_comb begin
        next_rdata = `BPC_READ_ZERO;
        if (hit(i_addr, `BPC_ADDR_PORT)) begin
            next_rdata = pins;
        end else if (hit(i_addr, `BPC_ADDR_DIR)) begin
            next_rdata = port_b_direction;
        end else if (hit(i_addr, `BPC_ADDR_OPTION)) begin
            next_rdata = core_option_config;
        end else if (hit(i_addr, `BPC_ADDR_INTCTL)) begin
            next_rdata[`BPC_INT_CHANGE] = change_flag;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= `BPC_READ_ZERO;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // programming mode hands pin 7 to the programming logic and forces pin 6 to input
    always_comb begin
        next_pin_out = port_b_data;
        next_pin_oe  = ~port_b_direction;
        if (i_prog_mode) begin
            next_pin_out[`BPC_PIN_PROG_DATA] = i_prog_data_out;
            next_pin_oe[`BPC_PIN_PROG_DATA]  = i_prog_data_oe;
            next_pin_oe[`BPC_PIN_PROG_CLOCK] = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pin_out <= `BPC_LATCH_POR;
            o_pin_oe  <= ~`BPC_DIR_RESET;
        end else begin
            o_pin_out <= next_pin_out;
            o_pin_oe  <= next_pin_oe;
        end
    end

    // pull-ups follow the global enable but never fight a driven pin
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pullup_en <= '0;
        end else begin
            o_pullup_en <= {8{~core_option_config[`BPC_OPT_PULLUP_N]}}
                           & port_b_direction & ~next_pin_oe;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_change_flag <= 1'b0;
            o_wake        <= 1'b0;
        end else begin
            o_change_flag <= change_flag;
            o_wake        <= change_flag;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ext_irq_in   <= 1'b0;
            o_prog_clock   <= 1'b0;
            o_prog_data_in <= 1'b0;
        end else begin
            o_ext_irq_in   <= pins[`BPC_PIN_EXT_IRQ];
            o_prog_clock   <= i_prog_mode && pins[`BPC_PIN_PROG_CLOCK];
            o_prog_data_in <= i_prog_mode && pins[`BPC_PIN_PROG_DATA];
        end
    end
endmodule : bpc_port

//--- logic/bpc_regs.svh
// Function
// - eight-bit port, every pin separately usable as input or output.
// - direction bit 1 floats the pin; 0 drives it from the output latch.
// - port read returns pin levels; port write updates only the output latch.
// - port write samples pins, merges modified bits, stores result in latch.
// - clearing option bit 7 turns on all weak pull-ups together.
// - a pin set as output never has its pull-up on.
// - after power-on reset all pull-ups are off.
// - only upper four input pins take part in change detection.
// - inputs compared with value from last port read or write; mismatches ORed into flag.
// - change flag can wake the core from sleep.
// - mismatch keeps setting flag; any port read or write refreshes comparison value.
// - pin change in the cycle of a port read may be missed.
// - pin 0 also feeds the external interrupt input.
// - pins 6 and 7 carry serial programming clock and data in programming mode.
// - every reset sets direction and option to ones; latch kept on other resets.
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH

`define BPC_ADDR_PORT      8'h06
`define BPC_ADDR_OPTION    8'h81
`define BPC_ADDR_DIR       8'h86
`define BPC_ADDR_INTCTL    8'h0C

`define BPC_DIR_RESET      8'hFF
`define BPC_OPTION_RESET   8'hFF
`define BPC_LATCH_POR      8'h00
`define BPC_READ_ZERO      8'h00

`define BPC_OPT_PULLUP_N   7
`define BPC_INT_CHANGE     0
`define BPC_PIN_EXT_IRQ    0
`define BPC_PIN_PROG_CLOCK 6
`define BPC_PIN_PROG_DATA  7
`define BPC_CHANGE_LO      4
`define BPC_CHANGE_HI      7

`endif

//--- logic/bpc_pkg.sv
package bpc_pkg;
    typedef logic [7:0] bpc_byte_type;
    typedef logic [3:0] bpc_nibble_type;
endpackage : bpc_pkg

//--- logic/bpc_sync.sv
`timescale 1ns/1ps
module bpc_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_bad_width
        $error("bpc_sync width must be at least one");
    end

    // first stage is read only by the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : bpc_sync

//--- logic/bpc_change_detect.sv
`timescale 1ns/1ps
module bpc_change_detect (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire bpc_pkg::bpc_nibble_type i_pins,
    input  wire bpc_pkg::bpc_nibble_type i_dir,
    input  wire logic                    i_refresh,
    input  wire logic                    i_clear,
    output logic                         o_flag,
    output logic                         o_mismatch
);
    bpc_pkg::bpc_nibble_type old_value;
    logic                    mismatch;

    // output pins masked out of the compare
    assign mismatch = |((i_pins ^ old_value) & i_dir);

    // a change landing in the refresh cycle is absorbed into the new value
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            old_value <= '0;
        end else if (i_refresh) begin
            old_value <= i_pins;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mismatch <= 1'b0;
        end else begin
            o_mismatch <= mismatch && !i_refresh;
        end
    end

    // set wins over clear so a short key press is not lost
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_flag <= 1'b0;
        end else if (mismatch && !i_refresh) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end
endmodule : bpc_change_detect

//--- testbench/bpc_port_asserts.sv
`timescale 1ns/1ps
module bpc_port_asserts (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic [7:0] i_addr,
    input wire logic       i_rd,
    input wire logic       i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_wmask,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] i_pin_in,
    input wire logic [7:0] o_pin_out,
    input wire logic [7:0] o_pin_oe,
    input wire logic [7:0] o_pullup_en,
    input wire logic       o_change_flag,
    input wire logic       o_wake,
    input wire logic       o_ext_irq_in,
    input wire logic       i_prog_mode,
    input wire logic       o_prog_clock
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire clr_now = i_wr && i_addr == 8'h0C && i_wmask[0] && !i_wdata[0];
    sequence s_dir_wr; i_wr && i_addr == 8'h86 && i_wmask == 8'hFF; endsequence
    sequence s_port_wr; i_wr && i_addr == 8'h06; endsequence
    sequence s_port_rd; $stable(i_pin_in)[*3] ##0 (i_rd && i_addr == 8'h06); endsequence
    chk_ext_follow: assert property ($stable(i_pin_in[0])[*4] |=>
        o_ext_irq_in == $past(i_pin_in[0])) else $error("ext irq not following pin");
    chk_prog_clock: assert property ($stable({i_prog_mode, i_pin_in[6]})[*4] |=>
        o_prog_clock == $past(i_prog_mode && i_pin_in[6])) else $error("prog clock wrong");
    chk_pullup_out: assert property ((o_pullup_en & o_pin_oe) == 8'h00)
        else $error("pull-up on driven pin");
    chk_dir_drive: assert property (s_dir_wr |-> ##3 o_pin_oe == ~$past(i_wdata, 3))
        else $error("drive enable wrong");
    chk_port_merge: assert property (s_port_wr |-> ##3
        ((o_pin_out ^ $past(i_wdata, 3)) & $past(i_wmask, 3)) == 8'h00)
        else $error("masked latch bits wrong");
    chk_read_pins: assert property (s_port_rd |=> o_rdata == $past(i_pin_in))
        else $error("port read not pin level");
    chk_wake_flag: assert property (o_wake == o_change_flag)
        else $error("wake differs from flag");
    chk_flag_sticky: assert property ($fell(o_change_flag) |->
        $past(clr_now) || $past(clr_now, 2)) else $error("flag dropped uncleared");
endmodule : bpc_port_asserts
bind bpc_port bpc_port_asserts bpc_port_asserts_i (.*);

//--- testbench/bpc_pin_model.sv
`timescale 1ns/1ps
module bpc_pin_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_drive,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    input  wire logic [7:0] i_ext,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_level
);
    logic [7:0] drift = 8'h55;
    // an undriven pin without pull-up wanders, so a stale value never reads as valid
    always_ff @(posedge i_clk) drift <= ~drift;
    always_comb o_level = (i_oe & i_drive) | (~i_oe & i_ext_en & i_ext)
        | (~i_oe & ~i_ext_en & (i_pullup | drift));
endmodule : bpc_pin_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic       i_clk = 0, i_reset = 1, i_soft_reset = 0, i_rd = 0, i_wr = 0, rdv = 0;
    logic       i_prog_mode = 0, i_prog_data_out = 0, i_prog_data_oe = 0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_wmask = 8'h00, lat = 8'h00;
    logic [7:0] ext = 8'h00, en = 8'hFF, w, m, exp_rd, i_pin_in, o_rdata, q[$];
    logic [7:0] o_pin_out, o_pin_oe, o_pullup_en;
    logic       o_change_flag, o_wake, o_ext_irq_in, o_prog_clock, o_prog_data_in;
    int         mismatches = 0, num_checks = 0, cyc = 0;
    always #25 i_clk = ~i_clk;
    bpc_port bpc_port_i (.i_clk, .i_reset, .i_soft_reset, .i_addr, .i_rd, .i_wr, .i_wdata,
        .i_wmask, .o_rdata, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pullup_en, .o_change_flag,
        .o_wake, .o_ext_irq_in, .i_prog_mode, .i_prog_data_out, .i_prog_data_oe,
        .o_prog_clock, .o_prog_data_in);
    bpc_pin_model bpc_pin_model_i (.i_clk, .i_drive(o_pin_out), .i_oe(o_pin_oe),
        .i_pullup(o_pullup_en), .i_ext(ext), .i_ext_en(en), .o_level(i_pin_in));
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic acc(input logic wr, input logic [7:0] a, d, k);
        @(negedge i_clk);
        i_addr = a; i_wdata = d; i_wmask = k; i_wr = wr; i_rd = !wr;
        @(negedge i_clk);
        i_wr = 0; i_rd = 0;
    endtask : acc
    task automatic rd(input logic [7:0] a, e);
        q.push_back(e);
        acc(0, a, 8'h00, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask : idle
    // read data answers one edge after the strobe, so it is judged at the next falling edge
    always @(posedge i_clk) rdv <= i_rd;
    always @(negedge i_clk) begin
        cyc++;
        if (rdv) begin
            exp_rd = q.pop_front();
            `CHK(o_rdata, exp_rd)
        end
        if (cyc > 2000) begin mismatches++; conclude(); end
    end
    initial begin
        void'($urandom(84));
        idle(12);
        i_reset = 0;
        `CHK(o_pullup_en, 8'h00)
        rd(8'h86, 8'hFF);
        rd(8'h81, 8'hFF);
        rd(8'h10, 8'h00);
        $display("reset test done");
        acc(1, 8'h81, 8'h7F, 8'hFF);
        en = 8'h00;
        idle(5);
        `CHK(o_pullup_en, 8'hFF)
        rd(8'h06, 8'hFF);
        en = 8'hFF;
        acc(1, 8'h86, 8'h0F, 8'hFF);
        idle(5);
        `CHK(o_pullup_en, 8'h0F)
        $display("pull-up test done");
        for (int i = 0; i < 4; i++) begin
            acc(1, 8'h86, 8'h0F, 8'hFF);
            ext = 8'($urandom());
            w = 8'($urandom());
            m = 8'($urandom());
            idle(5);
            lat = ({lat[7:4], ext[3:0]} & ~m) | (w & m);
            acc(1, 8'h06, w, m);
            idle(5);
            rd(8'h06, {lat[7:4], ext[3:0]});
            acc(1, 8'h86, 8'h00, 8'hFF);
            idle(5);
            rd(8'h06, lat);
        end
        $display("merge test done");
        acc(1, 8'h86, 8'hFF, 8'hFF);
        ext = 8'h00;
        idle(5);
        rd(8'h06, 8'h00);
        acc(1, 8'h0C, 8'h00, 8'h01);
        ext = 8'h02;
        idle(6);
        `CHK(o_change_flag, 1'b0)
        ext = 8'h22;
        idle(2);
        ext = 8'h02;
        idle(6);
        `CHK({o_change_flag, o_wake}, 2'b11)
        rd(8'h06, 8'h02);
        acc(1, 8'h0C, 8'h00, 8'h01);
        idle(3);
        `CHK(o_change_flag, 1'b0)
        ext = 8'h82;
        idle(6);
        acc(1, 8'h0C, 8'h00, 8'h01);
        idle(3);
        `CHK(o_change_flag, 1'b1)
        rd(8'h0C, 8'h01);
        rd(8'h06, 8'h82);
        acc(1, 8'h0C, 8'h00, 8'h01);
        acc(1, 8'h86, 8'h7F, 8'hFF);
        idle(6);
        acc(1, 8'h06, 8'h00, 8'h80);
        idle(6);
        `CHK(o_change_flag, 1'b0)
        $display("change test done");
        i_prog_mode = 1;
        ext = 8'hC1;
        idle(6);
        `CHK({o_ext_irq_in, o_prog_clock, o_prog_data_in}, 3'b111)
        ext = 8'h00;
        idle(6);
        `CHK({o_ext_irq_in, o_prog_clock, o_prog_data_in}, 3'b000)
        i_prog_data_oe = 1;
        i_prog_data_out = 1;
        idle(4);
        `CHK({o_pin_oe[7], o_pin_out[7]}, 2'b11)
        i_prog_mode = 0;
        i_prog_data_oe = 0;
        $display("shared pin test done");
        idle(1);
        i_soft_reset = 1;
        idle(1);
        i_soft_reset = 0;
        rd(8'h86, 8'hFF);
        rd(8'h81, 8'hFF);
        acc(1, 8'h86, 8'h00, 8'hFF);
        idle(5);
        rd(8'h06, 8'h02);
        idle(2);
        $display("soft reset test done");
        conclude();
    end
endmodule : tb_top
